// >>> hdl/scsd_pkg.sv
// Package: register map, field layout and constants of the clock switch block
package scsd_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_OSC_CTRL = 8'h00;
  localparam logic [7:0] OFF_CLK_DIV = 8'h04;
  localparam logic [7:0] OFF_PLL_FBD = 8'h08;
  localparam logic [7:0] OFF_RC_TUNE = 8'h0c;
  localparam logic [7:0] OFF_AUX_CTRL = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  // Oscillator control field positions
  localparam int CUR_LSB = 12;
  localparam int REQ_LSB = 8;
  localparam int SRC_LOCK_BIT = 7;
  localparam int PIN_LOCK_BIT = 6;
  localparam int PLL_LOCK_BIT = 5;
  localparam int FAIL_BIT = 3;
  localparam int SEC_EN_BIT = 1;
  localparam int SW_REQ_BIT = 0;
  // Clock divisor field positions
  localparam int ROI_BIT = 15;
  localparam int DOZE_LSB = 12;
  localparam int DOZE_EN_BIT = 11;
  // Write masks of implemented bits
  localparam logic [15:0] CLK_DIV_MASK = 16'hffdf;
  localparam logic [15:0] PLL_FBD_MASK = 16'h01ff;
  localparam logic [15:0] RC_TUNE_MASK = 16'h003f;
  localparam logic [15:0] AUX_CTRL_MASK = 16'h3f80;
  localparam logic [15:0] OSC_WR_MASK = 16'h00c3;
  // Power-on values
  localparam logic [15:0] CLK_DIV_RST = 16'h3040;
  localparam logic [15:0] PLL_FBD_RST = 16'h0030;
  localparam logic [15:0] RC_TUNE_RST = 16'h0000;
  localparam logic [15:0] AUX_CTRL_RST = 16'h0000;
  // Source encoding
  localparam logic [2:0] SRC_FRC = 3'h0;
  localparam logic [2:0] SRC_FRC_PLL = 3'h1;
  localparam logic [2:0] SRC_PRI = 3'h2;
  localparam logic [2:0] SRC_PRI_PLL = 3'h3;
  localparam logic [2:0] SRC_SEC = 3'h4;
  localparam logic [2:0] SRC_LOW_POWER_RC_OSCILLATOR = 3'h5;
  // Settling count on the new source
  localparam logic [3:0] SETTLE_CYCLES = 4'ha;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [4:0] {
    SW_IDLE = 5'h01,
    SW_START = 5'h02,
    SW_WAIT = 5'h04,
    SW_SETTLE = 5'h08,
    SW_DONE = 5'h10
  } scsd_sw_t;
endpackage

// >>> hdl/scsd_top.sv
// Clock-source switch controller with divider registers on AXI4-Lite
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module scsd_top (
  // Clock and power-on reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Configuration straps
  input wire logic switch_monitor_config_i,
  input wire logic [2:0] initial_source_config_i,
  input wire logic [1:0] primary_submode_config_i,
  input wire logic watchdog_enable_i,
  // Oscillator status from the analog side
  input wire logic startup_timer_done_i,
  input wire logic pll_locked_i,
  input wire logic new_src_tick_i,
  input wire logic clock_fail_i,
  input wire logic interrupt_i,
  // Oscillator controls
  output logic [2:0] current_source_o,
  output logic [1:0] primary_submode_o,
  output logic [7:0] src_run_o,
  output logic switch_busy_o,
  output logic [15:0] clk_div_o,
  output logic [15:0] pll_fbd_o,
  output logic [15:0] rc_tune_o,
  output logic [15:0] aux_ctrl_o
);

  // ===========================================================
  // State
  typedef struct packed {
    logic [1:0] ini;
    logic cfg_off;
    logic [1:0] submode;
    logic [2:0] cur;
    logic [2:0] req;
    logic src_lock;
    logic pin_lock;
    logic pll_lock;
    logic fail;
    logic sec_en;
    logic sw_req;
    logic [15:0] clk_div;
    logic [15:0] pll_fbd;
    logic [15:0] rc_tune;
    logic [15:0] aux_ctrl;
    scsd_pkg::scsd_sw_t sw;
    logic [3:0] settle;
    logic [7:0] run;
    logic [1:0] st_s1;
    logic [1:0] st_s2;
    logic [3:0] sy1;
    logic [3:0] sy2;
    logic tick_q;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } scsd_state_t;

  scsd_state_t st_reg;
  scsd_state_t st_next;

  // ===========================================================
  // Helpers
  function automatic logic [7:0] src_bit(input logic [2:0] s);
    src_bit = 8'h01 << s;
  endfunction

  function automatic logic needs_pll(input logic [2:0] s);
    needs_pll = (s == scsd_pkg::SRC_FRC_PLL) || (s == scsd_pkg::SRC_PRI_PLL);
  endfunction

  function automatic logic is_crystal(input logic [2:0] s, input logic [1:0] sm);
    is_crystal = (s == scsd_pkg::SRC_SEC) ||
                 (((s == scsd_pkg::SRC_PRI) || (s == scsd_pkg::SRC_PRI_PLL)) && (sm != 2'h0));
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] be, input logic [15:0] m);
    logic [15:0] v;
    v = old;
    if (be[0]) begin
      v[7:0] = d[7:0];
    end
    if (be[1]) begin
      v[15:8] = d[15:8];
    end
    merge16 = (v & m) | (old & ~m);
  endfunction

  // ===========================================================
  // Next state
  localparam int CURB = scsd_pkg::CUR_LSB;
  localparam int REQB = scsd_pkg::REQ_LSB;
  logic [15:0] osc_rd;
  logic do_wr;
  logic [15:0] owr;
  logic st_done;
  logic lk_in;
  logic fail_in;
  logic irq_in;
  logic tick_rise;

  always_comb begin
    st_next = st_reg;
    // Synchronised pins: startup timer, lock, fail, interrupt
    st_next.sy1 = {interrupt_i, clock_fail_i, pll_locked_i, startup_timer_done_i};
    st_next.sy2 = st_reg.sy1;
    st_next.st_s1 = {new_src_tick_i, 1'b0};
    st_next.st_s2 = st_reg.st_s1;
    st_next.tick_q = st_reg.st_s2[1];
    st_done = st_reg.sy2[0];
    lk_in = st_reg.sy2[1];
    fail_in = st_reg.sy2[2];
    irq_in = st_reg.sy2[3];
    tick_rise = st_reg.st_s2[1] && !st_reg.tick_q;

    osc_rd = 16'h0000;
    osc_rd[CURB +: 3] = st_reg.cur;
    osc_rd[REQB +: 3] = st_reg.req;
    osc_rd[scsd_pkg::SRC_LOCK_BIT] = st_reg.src_lock;
    osc_rd[scsd_pkg::PIN_LOCK_BIT] = st_reg.pin_lock;
    osc_rd[scsd_pkg::PLL_LOCK_BIT] = st_reg.pll_lock;
    osc_rd[scsd_pkg::FAIL_BIT] = st_reg.fail;
    osc_rd[scsd_pkg::SEC_EN_BIT] = st_reg.sec_en;
    osc_rd[scsd_pkg::SW_REQ_BIT] = st_reg.sw_req;

    // AXI write channel capture
    st_next.awready = 1'b0;
    st_next.wready = 1'b0;
    if (s_axi_awvalid && !st_reg.aw_got && !st_reg.awready && !st_reg.bvalid) begin
      st_next.awready = 1'b1;
      st_next.aw_got = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_got && !st_reg.wready && !st_reg.bvalid) begin
      st_next.wready = 1'b1;
      st_next.w_got = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    do_wr = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
    owr = merge16(osc_rd, st_reg.w_data, st_reg.w_strb, scsd_pkg::OSC_WR_MASK);
    if (s_axi_bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    if (do_wr) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = scsd_pkg::AXI_OKAY;
      unique case (st_reg.aw_addr)
        scsd_pkg::OFF_OSC_CTRL: begin
          if (!st_reg.cfg_off && st_reg.w_strb[1] && st_reg.sw == scsd_pkg::SW_IDLE) begin
            st_next.req = st_reg.w_data[REQB +: 3];
          end
          st_next.src_lock = owr[scsd_pkg::SRC_LOCK_BIT] | st_reg.src_lock;
          st_next.pin_lock = owr[scsd_pkg::PIN_LOCK_BIT];
          st_next.sec_en = owr[scsd_pkg::SEC_EN_BIT];
          if (st_reg.w_strb[0] && !st_reg.w_data[scsd_pkg::FAIL_BIT]) begin
            st_next.fail = 1'b0;
          end
          // Request ignored while disabled or locked, lock set in this write too
          if (owr[scsd_pkg::SW_REQ_BIT] && !st_reg.cfg_off && !st_next.src_lock) begin
            st_next.sw_req = 1'b1;
          end
        end
        scsd_pkg::OFF_CLK_DIV: begin
          st_next.clk_div = merge16(st_reg.clk_div, st_reg.w_data, st_reg.w_strb,
                                    scsd_pkg::CLK_DIV_MASK);
        end
        scsd_pkg::OFF_PLL_FBD: begin
          st_next.pll_fbd = merge16(st_reg.pll_fbd, st_reg.w_data, st_reg.w_strb,
                                    scsd_pkg::PLL_FBD_MASK);
        end
        scsd_pkg::OFF_RC_TUNE: begin
          st_next.rc_tune = merge16(st_reg.rc_tune, st_reg.w_data, st_reg.w_strb,
                                    scsd_pkg::RC_TUNE_MASK);
        end
        scsd_pkg::OFF_AUX_CTRL: begin
          st_next.aux_ctrl = merge16(st_reg.aux_ctrl, st_reg.w_data, st_reg.w_strb,
                                     scsd_pkg::AUX_CTRL_MASK);
        end
        scsd_pkg::OFF_STATUS: begin
        end
        default: begin
          st_next.bresp = scsd_pkg::AXI_SLVERR;
        end
      endcase
    end

    // AXI read channel
    st_next.arready = 1'b0;
    if (s_axi_rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_reg.arready && !st_reg.rvalid) begin
      st_next.arready = 1'b1;
      st_next.rvalid = 1'b1;
      st_next.rresp = scsd_pkg::AXI_OKAY;
      st_next.rdata = 32'h0000_0000;
      unique case (s_axi_araddr)
        scsd_pkg::OFF_OSC_CTRL: st_next.rdata[15:0] = osc_rd;
        scsd_pkg::OFF_CLK_DIV: st_next.rdata[15:0] = st_reg.clk_div;
        scsd_pkg::OFF_PLL_FBD: st_next.rdata[15:0] = st_reg.pll_fbd;
        scsd_pkg::OFF_RC_TUNE: st_next.rdata[15:0] = st_reg.rc_tune;
        scsd_pkg::OFF_AUX_CTRL: st_next.rdata[15:0] = st_reg.aux_ctrl;
        scsd_pkg::OFF_STATUS: st_next.rdata[12:0] = {st_reg.run, st_reg.sw};
        default: st_next.rresp = scsd_pkg::AXI_SLVERR;
      endcase
    end

    // Doze recovery on interrupt
    if (st_reg.clk_div[scsd_pkg::ROI_BIT] && irq_in) begin
      st_next.clk_div[scsd_pkg::DOZE_EN_BIT] = 1'b0;
    end

    // PLL lock status follows lock only while a PLL source runs
    if (st_reg.sw == scsd_pkg::SW_IDLE || st_reg.sw == scsd_pkg::SW_WAIT) begin
      st_next.pll_lock = lk_in && (needs_pll(st_reg.cur) ||
                         (st_reg.sw == scsd_pkg::SW_WAIT && needs_pll(st_reg.req)));
    end

    // Switch sequencer
    unique case (st_reg.sw)
      scsd_pkg::SW_IDLE: begin
        if (st_reg.sw_req) begin
          if (st_reg.req == st_reg.cur) begin
            st_next.sw_req = 1'b0;
          end else begin
            st_next.pll_lock = 1'b0;
            st_next.fail = 1'b0;
            st_next.run = st_reg.run | src_bit(st_reg.req);
            st_next.sw = scsd_pkg::SW_START;
          end
        end
      end
      scsd_pkg::SW_START: begin
        st_next.sw = scsd_pkg::SW_WAIT;
      end
      scsd_pkg::SW_WAIT: begin
        if ((!is_crystal(st_reg.req, st_reg.submode) || st_done) &&
            (!needs_pll(st_reg.req) || lk_in)) begin
          st_next.settle = 4'h0;
          st_next.sw = scsd_pkg::SW_SETTLE;
        end
      end
      scsd_pkg::SW_SETTLE: begin
        if (tick_rise) begin
          st_next.settle = st_reg.settle + 4'h1;
          if (st_reg.settle + 4'h1 == scsd_pkg::SETTLE_CYCLES) begin
            st_next.sw = scsd_pkg::SW_DONE;
          end
        end
      end
      scsd_pkg::SW_DONE: begin
        st_next.cur = st_reg.req;
        st_next.sw_req = 1'b0;
        st_next.run = src_bit(st_reg.req);
        if (watchdog_enable_i || !st_reg.cfg_off) begin
          st_next.run[scsd_pkg::SRC_LOW_POWER_RC_OSCILLATOR] = 1'b1;
        end
        if (st_reg.sec_en) begin
          st_next.run[scsd_pkg::SRC_SEC] = 1'b1;
        end
        st_next.sw = scsd_pkg::SW_IDLE;
      end
      default: st_next.sw = scsd_pkg::SW_IDLE;
    endcase

    // Failure event wins over a software clear
    if (fail_in && !st_reg.cfg_off) begin
      st_next.fail = 1'b1;
    end

    // Capture configuration on the second edge after power-on release
    if (st_reg.ini == 2'h1) begin
      st_next.cfg_off = switch_monitor_config_i;
      st_next.submode = primary_submode_config_i;
      st_next.cur = initial_source_config_i;
      st_next.req = initial_source_config_i;
      st_next.run = src_bit(initial_source_config_i);
      st_next.ini = 2'h2;
    end else if (st_reg.ini == 2'h0) begin
      st_next.ini = 2'h1;
    end
  end

  // ===========================================================
  // Registers, reset only by power-on
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_reg <= '0;
      st_reg.clk_div <= scsd_pkg::CLK_DIV_RST;
      st_reg.pll_fbd <= scsd_pkg::PLL_FBD_RST;
      st_reg.rc_tune <= scsd_pkg::RC_TUNE_RST;
      st_reg.aux_ctrl <= scsd_pkg::AUX_CTRL_RST;
      st_reg.cfg_off <= 1'b1;
      st_reg.sw <= scsd_pkg::SW_IDLE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ===========================================================
  // Outputs; divider codes go to the analog side unchanged
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign current_source_o = st_reg.cur;
  assign primary_submode_o = st_reg.submode;
  assign src_run_o = st_reg.run;
  assign switch_busy_o = st_reg.sw_req;
  assign clk_div_o = st_reg.clk_div;
  assign pll_fbd_o = st_reg.pll_fbd;
  assign rc_tune_o = st_reg.rc_tune;
  assign aux_ctrl_o = st_reg.aux_ctrl;

  // ===========================================================
  // Checks
  chk_redundant_abort: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (st_reg.sw == scsd_pkg::SW_IDLE && st_reg.sw_req && st_reg.req == st_reg.cur)
    |=> !st_reg.sw_req && st_reg.sw == scsd_pkg::SW_IDLE)
    else $error("redundant switch not aborted");
  chk_accept_clears: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (st_reg.sw == scsd_pkg::SW_IDLE && st_reg.sw_req && st_reg.req != st_reg.cur)
    |=> !st_reg.pll_lock)
    else $error("lock status not cleared on switch");
  chk_done_copy: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    st_reg.sw == scsd_pkg::SW_DONE |=> st_reg.cur == $past(st_reg.req) && !st_reg.sw_req)
    else $error("switch completion wrong");
  chk_settle_count: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(st_reg.sw == scsd_pkg::SW_DONE) |-> $past(st_reg.settle) == 4'h9)
    else $error("settle count wrong");
  chk_cfg_off_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (st_reg.cfg_off && st_reg.ini == 2'h2) |-> !st_reg.sw_req)
    else $error("request set while switching disabled");
  chk_locked_src: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (st_reg.src_lock && st_reg.sw == scsd_pkg::SW_IDLE && !st_reg.sw_req) |=> $stable(st_reg.cur))
    else $error("source changed while locked");
  chk_roi_doze: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (st_reg.clk_div[scsd_pkg::ROI_BIT] && irq_in) |=> !st_reg.clk_div[scsd_pkg::DOZE_EN_BIT])
    else $error("doze not cleared on interrupt");
  chk_fail_sets: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (fail_in && !st_reg.cfg_off) |=> st_reg.fail)
    else $error("fail flag not set");
  cov_switch: cover property (@(posedge clk_i) st_reg.sw == scsd_pkg::SW_DONE);
  cov_redundant: cover property (@(posedge clk_i)
    st_reg.sw_req && st_reg.req == st_reg.cur && st_reg.sw == scsd_pkg::SW_IDLE);
  cov_fail: cover property (@(posedge clk_i) $rose(st_reg.fail));
endmodule

// >>> tb/tb_top.sv
// Self-checking testbench of the clock switch block
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic sm_cfg = 1'b0, wdog = 1'b0, startup_timer = 1'b1, pll = 1'b1, tick = 1'b0, fail_in = 1'b0;
  logic irq = 1'b0;
  logic [2:0] init_cfg = 3'h0;
  logic [1:0] sub_cfg = 2'h1;
  logic [2:0] cur;
  logic [1:0] sub;
  logic [7:0] run;
  logic busy;
  logic [15:0] cdiv, fbd, tune, aux;
  logic [1:0] rsp;
  int fails = 0, num_checks = 0, cycles = 0, n;

  scsd_top u_scsd_top (.clk_i(clk_i), .arst_n_i(arst_n_i), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .switch_monitor_config_i(sm_cfg), .initial_source_config_i(init_cfg),
    .primary_submode_config_i(sub_cfg), .watchdog_enable_i(wdog),
    .startup_timer_done_i(startup_timer), .pll_locked_i(pll), .new_src_tick_i(tick),
    .clock_fail_i(fail_in), .interrupt_i(irq), .current_source_o(cur),
    .primary_submode_o(sub), .src_run_o(run), .switch_busy_o(busy), .clk_div_o(cdiv),
    .pll_fbd_o(fbd), .rc_tune_o(tune), .aux_ctrl_o(aux));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  // ==========
  // Checking and bus tasks
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_i);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_i);
      if (awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_i); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_i); while (rvalid !== 1'b1);
    rsp = rresp;
    arvalid <= 1'b0;
    rready <= 1'b0;
    chk(rdata & m, exp);
  endtask

  task automatic do_reset;
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic pulses(input int k);
    repeat (k) begin
      @(posedge clk_i);
      tick <= 1'b1;
      repeat (3) @(posedge clk_i);
      tick <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
  endtask

  task automatic run_switch(output int k);
    k = 0;
    while (busy === 1'b1 && k < 40) begin
      pulses(1);
      k++;
    end
  endtask

  // ==========
  // Scenarios
  task automatic t_defaults;
    rd(scsd_pkg::OFF_CLK_DIV, 32'hffffffff, 32'h3040);
    rd(scsd_pkg::OFF_PLL_FBD, 32'hffffffff, 32'h0030);
    rd(scsd_pkg::OFF_AUX_CTRL, 32'hffffffff, 32'h0000);
    rd(scsd_pkg::OFF_OSC_CTRL, 32'h7000, 32'h0000);
    chk(cdiv, 32'h3040);
  endtask

  task automatic t_fields;
    wr(scsd_pkg::OFF_RC_TUNE, 32'hffffffff);
    rd(scsd_pkg::OFF_RC_TUNE, 32'hffffffff, 32'h003f);
    wr(scsd_pkg::OFF_AUX_CTRL, 32'hffffffff);
    rd(scsd_pkg::OFF_AUX_CTRL, 32'hffffffff, 32'h3f80);
    wr(scsd_pkg::OFF_PLL_FBD, 32'hffffffff);
    rd(scsd_pkg::OFF_PLL_FBD, 32'hffffffff, 32'h01ff);
    wr(8'h18, 32'h0000ffff);
    chk(rsp, scsd_pkg::AXI_SLVERR);
    rd(8'h18, 32'hffffffff, 32'h0);
    chk(rsp, scsd_pkg::AXI_SLVERR);
  endtask

  task automatic t_doze;
    wr(scsd_pkg::OFF_CLK_DIV, 32'h0000b840);
    rd(scsd_pkg::OFF_CLK_DIV, 32'hffffffff, 32'hb840);
    @(posedge clk_i);
    irq <= 1'b1;
    repeat (4) @(posedge clk_i);
    irq <= 1'b0;
    rd(scsd_pkg::OFF_CLK_DIV, 32'hffffffff, 32'hb040);
  endtask

  task automatic t_switches;
    wr(scsd_pkg::OFF_OSC_CTRL, 32'h00000001);
    repeat (6) @(posedge clk_i);
    chk(busy, 1'b0);
    chk(cur, 3'h0);
    @(posedge clk_i);
    fail_in <= 1'b1;
    repeat (4) @(posedge clk_i);
    fail_in <= 1'b0;
    rd(scsd_pkg::OFF_OSC_CTRL, 32'h0008, 32'h0008);
    // Bit 3 written as 1 keeps the fail flag, so here the accepted switch clears it
    wr(scsd_pkg::OFF_OSC_CTRL, 32'h00000508);
    wr(scsd_pkg::OFF_OSC_CTRL, 32'h00000509);
    chk(busy, 1'b1);
    run_switch(n);
    chk(n, 32'd10);
    chk(cur, 3'h5);
    rd(scsd_pkg::OFF_OSC_CTRL, 32'h702b, 32'h5000);
    chk(run[0], 1'b0);
    chk(run[5], 1'b1);
    pll <= 1'b0;
    wr(scsd_pkg::OFF_OSC_CTRL, 32'h00000101);
    pulses(14);
    chk(busy, 1'b1);
    chk(cur, 3'h5);
    pll <= 1'b1;
    run_switch(n);
    chk(n, 32'd10);
    chk(cur, 3'h1);
    rd(scsd_pkg::OFF_OSC_CTRL, 32'h7020, 32'h1020);
    @(posedge clk_i);
    fail_in <= 1'b1;
    repeat (4) @(posedge clk_i);
    fail_in <= 1'b0;
    wr(scsd_pkg::OFF_OSC_CTRL, 32'h00000100);
    rd(scsd_pkg::OFF_OSC_CTRL, 32'h0008, 32'h0000);
    wr(scsd_pkg::OFF_OSC_CTRL, 32'h00000081);
    pulses(14);
    chk(busy, 1'b0);
    chk(cur, 3'h1);
  endtask

  task automatic t_disabled;
    sm_cfg <= 1'b1;
    init_cfg <= 3'h2;
    sub_cfg <= 2'h2;
    do_reset();
    chk(cur, 3'h2);
    chk(sub, 2'h2);
    chk(tune, 32'h0);
    chk(cdiv, 32'h3040);
    wr(scsd_pkg::OFF_OSC_CTRL, 32'h00000001);
    repeat (4) @(posedge clk_i);
    chk(busy, 1'b0);
    rd(scsd_pkg::OFF_OSC_CTRL, 32'h7001, 32'h2000);
  endtask

  initial begin
    do_reset();
    t_defaults();
    t_fields();
    t_doze();
    t_switches();
    t_disabled();
    complete_run();
  end
endmodule
